// ==== api_framer_pkg.sv ====
/*
  constants, offsets and carrier structs for the api frame encoder and decoder.
  assumes a byte-wide uart stream on the same clock on both sides.
*/
// Function
// - every frame opens with 0x7E and a two-byte length, high byte first, counting type to data.
// - the last byte is 0xFF minus the 8-bit sum of type through data, made on send, checked on receive.
// - offsets 16 and 17 hold the command name; parameter bytes after them mean write, none means query.
// - a nonzero frame id asks for a reply, and a zero id means no response frame is sent.
// - the device answers a command with a type 0x88 frame whose id at offset 4 echoes the request.
// - one request may be answered by several response frames in a row.
// - response offsets 5 and 6 hold the command name and offset 7 the status code.
// - status 0 is success, 1 general error, 2 unknown command, 3 bad parameter.
// - a query reply carries the value after the status, a write reply carries no data.
// - each response carries the frame id of the request that it reports.
// - unsolicited modem status frames are type 0x8A with one status byte at offset 4.
// - modem status 0x00 is hardware reset, 0x01 watchdog, 0x0B network wake, 0x0C network sleep.
// - after power-up the device sends a modem status frame with the hardware reset code.
package api_framer_pkg;

  // framing bytes
  localparam logic [7:0] START_DELIM = 8'h7E;
  localparam logic [7:0] CSUM_BASE = 8'hFF;
  localparam int HDR_BYTES = 3;

  // frame types
  localparam logic [7:0] TYPE_REMOTE_REQ = 8'h17;
  localparam logic [7:0] TYPE_CMD_RESP = 8'h88;
  localparam logic [7:0] TYPE_MODEM_STATUS = 8'h8A;

  // remote request frame offsets
  localparam int REQ_OFS_TYPE = 3;
  localparam int REQ_OFS_ID = 4;
  localparam int REQ_OFS_ADDR = 5;
  localparam int REQ_OFS_RSVD_HI = 13;
  localparam int REQ_OFS_RSVD_LO = 14;
  localparam int REQ_OFS_OPTIONS = 15;
  localparam int REQ_OFS_CMD_HI = 16;
  localparam int REQ_OFS_CMD_LO = 17;
  localparam int REQ_OFS_PARAM = 18;
  localparam logic [15:0] REQ_MIN_LEN = 16'h000F;

  // request field values
  localparam logic [7:0] OPT_APPLY_CHANGES = 8'h02;
  localparam logic [15:0] RSVD_ADDR16 = 16'hFFFE;
  localparam logic [63:0] BROADCAST_ADDR = 64'h0000_0000_0000_FFFF;

  // response frame offsets
  localparam int RSP_OFS_TYPE = 3;
  localparam int RSP_OFS_ID = 4;
  localparam int RSP_OFS_CMD_HI = 5;
  localparam int RSP_OFS_CMD_LO = 6;
  localparam int RSP_OFS_STATUS = 7;
  localparam int RSP_OFS_DATA = 8;
  localparam logic [15:0] RSP_FIXED_LEN = 16'h0005;

  // response status codes
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_ERROR = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_PARAM = 8'h03;

  // modem status frame
  localparam int MDM_OFS_TYPE = 3;
  localparam int MDM_OFS_STATUS = 4;
  localparam logic [15:0] MDM_LEN = 16'h0002;
  localparam logic [7:0] MDM_HW_RESET = 8'h00;
  localparam logic [7:0] MDM_WDOG_RESET = 8'h01;
  localparam logic [7:0] MDM_NET_WAKE = 8'h0B;
  localparam logic [7:0] MDM_NET_SLEEP = 8'h0C;

  // buffer sizes
  localparam int PARAM_MAX = 8;
  localparam int DATA_MAX = 8;
  localparam int RX_BUF_MAX = 23;
  localparam logic [15:0] RX_LEN_MAX = 16'h0017;

  // decoded remote request
  typedef struct packed {
    logic [7:0] frame_id;
    logic [63:0] dest_addr;
    logic broadcast;
    logic apply_changes;
    logic options_bad;
    logic reserved_bad;
    logic [15:0] cmd_name;
    logic is_query;
    logic [3:0] param_len;
    logic [PARAM_MAX-1:0][7:0] param;
  } remote_req_s;

  // response to be framed
  typedef struct packed {
    logic [7:0] frame_id;
    logic [15:0] cmd_name;
    logic [7:0] status;
    logic is_query;
    logic [3:0] data_len;
    logic [DATA_MAX-1:0][7:0] data;
  } cmd_resp_s;

endpackage

// ==== frame_serializer.sv ====
/*
  serializer that wraps a frame body with delimiter, length and checksum.
  assumes the body source holds still while busy_out is high.
*/
module frame_serializer (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [15:0] body_len_in,
  output logic busy_out,
  output logic [15:0] rd_idx_out,
  input wire logic [7:0] rd_byte_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in
);

  typedef enum logic [2:0] {S_IDLE, S_DELIM, S_LEN_HI, S_LEN_LO, S_BODY, S_CSUM} ser_state_e;

  ser_state_e state;
  logic [15:0] len;
  logic [15:0] cnt;
  logic [7:0] sum;
  logic out_free;

  // output slot may take a new byte
  assign out_free = !tx_valid_out || tx_ready_in;
  assign busy_out = (state != S_IDLE);
  assign rd_idx_out = cnt;

  // frame sequencer and output byte register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= S_IDLE;
      len <= 16'h0000;
      cnt <= 16'h0000;
      sum <= 8'h00;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
    end else begin
      if (out_free) begin
        tx_valid_out <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (start_in) begin
            len <= body_len_in;
            state <= S_DELIM;
          end
        end
        S_DELIM: begin
          if (out_free) begin
            tx_valid_out <= 1'b1;
            tx_data_out <= api_framer_pkg::START_DELIM;
            state <= S_LEN_HI;
          end
        end
        S_LEN_HI: begin
          if (out_free) begin
            tx_valid_out <= 1'b1;
            tx_data_out <= len[15:8];
            state <= S_LEN_LO;
          end
        end
        S_LEN_LO: begin
          if (out_free) begin
            tx_valid_out <= 1'b1;
            tx_data_out <= len[7:0];
            cnt <= 16'h0000;
            sum <= 8'h00;
            state <= S_BODY;
          end
        end
        S_BODY: begin
          if (out_free) begin
            tx_valid_out <= 1'b1;
            tx_data_out <= rd_byte_in;
            sum <= sum + rd_byte_in;
            cnt <= cnt + 16'h0001;
            if (cnt == len - 16'h0001) begin
              state <= S_CSUM;
            end
          end
        end
        S_CSUM: begin
          if (out_free) begin
            tx_valid_out <= 1'b1;
            tx_data_out <= api_framer_pkg::CSUM_BASE - sum;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // frame_serializer

// ==== api_remote_cmd_response_framer.sv ====
/*
  api frame decoder for remote configuration requests and encoder for
  command responses and modem status frames.
  assumes a uart byte stream and user logic on the same clock, with no pins
  crossing in directly.
*/
module api_remote_cmd_response_framer (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // receive byte stream from the uart
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  // decoded requests
  output logic req_valid_out,
  output api_framer_pkg::remote_req_s req_out,
  output logic frame_error_out,
  // responses from the command engine
  input wire logic resp_valid_in,
  output logic resp_ready_out,
  input wire api_framer_pkg::cmd_resp_s resp_in,
  // modem events
  input wire logic wdog_reset_in,
  input wire logic net_wake_in,
  input wire logic net_sleep_in,
  // transmit byte stream to the uart
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in
);

  typedef enum logic [2:0] {R_HUNT, R_LEN_HI, R_LEN_LO, R_BODY, R_CSUM} rx_state_e;
  typedef enum logic {SRC_MODEM, SRC_RESP} tx_src_e;

  rx_state_e rx_state;
  logic [15:0] rx_len;
  logic [15:0] rx_cnt;
  logic [7:0] rx_sum;
  logic [7:0] rx_buf [api_framer_pkg::RX_BUF_MAX];
  logic [63:0] dec_addr;
  logic [api_framer_pkg::PARAM_MAX-1:0][7:0] dec_param;
  logic [15:0] dec_param_len;
  logic frame_ok;

  tx_src_e tx_src;
  api_framer_pkg::cmd_resp_s resp_held;
  logic resp_pending;
  logic [7:0] modem_code;
  logic hw_pend;
  logic wdog_pend;
  logic wake_pend;
  logic sleep_pend;
  logic ser_start;
  logic ser_busy;
  logic launch;
  logic launch_modem;
  logic [7:0] next_modem_code;
  logic [15:0] body_len;
  logic [15:0] rd_idx;
  logic [7:0] rd_byte;

  // --------------------------------------------------------------
  // receive side
  // --------------------------------------------------------------

  // checksum over body plus received checksum must land on all ones
  assign frame_ok = (rx_sum + rx_data_in) == api_framer_pkg::CSUM_BASE;

  // receive frame tracker, drops bad frames and hunts for the next delimiter
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_state <= R_HUNT;
      rx_len <= 16'h0000;
      rx_cnt <= 16'h0000;
      rx_sum <= 8'h00;
    end else if (rx_valid_in) begin
      case (rx_state)
        R_HUNT: begin
          if (rx_data_in == api_framer_pkg::START_DELIM) begin
            rx_state <= R_LEN_HI;
          end
        end
        R_LEN_HI: begin
          rx_len[15:8] <= rx_data_in;
          rx_state <= R_LEN_LO;
        end
        R_LEN_LO: begin
          rx_len[7:0] <= rx_data_in;
          rx_cnt <= 16'h0000;
          rx_sum <= 8'h00;
          if ({rx_len[15:8], rx_data_in} == 16'h0000 ||
              {rx_len[15:8], rx_data_in} > api_framer_pkg::RX_LEN_MAX) begin
            rx_state <= R_HUNT;
          end else begin
            rx_state <= R_BODY;
          end
        end
        R_BODY: begin
          rx_sum <= rx_sum + rx_data_in;
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_cnt == rx_len - 16'h0001) begin
            rx_state <= R_CSUM;
          end
        end
        R_CSUM: begin
          rx_state <= R_HUNT;
        end
        default: begin
          rx_state <= R_HUNT;
        end
      endcase
    end
  end

  // body bytes land in the frame buffer by position
  always_ff @(posedge core_clk_in) begin
    if (rx_valid_in && rx_state == R_BODY) begin
      rx_buf[rx_cnt[4:0]] <= rx_data_in;
    end
  end

  // address and parameter bytes unpacked from the buffer
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_addr
      // high byte first at the lowest offset
      assign dec_addr[63-8*gi -: 8] =
        rx_buf[api_framer_pkg::REQ_OFS_ADDR - api_framer_pkg::HDR_BYTES + gi];
    end
    for (gi = 0; gi < api_framer_pkg::PARAM_MAX; gi++) begin : g_param
      assign dec_param[gi] =
        rx_buf[api_framer_pkg::REQ_OFS_PARAM - api_framer_pkg::HDR_BYTES + gi];
    end
  endgenerate

  assign dec_param_len = rx_len - api_framer_pkg::REQ_MIN_LEN;

  // decoded request and error pulses at the checksum byte
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_valid_out <= 1'b0;
      frame_error_out <= 1'b0;
      req_out <= '0;
    end else begin
      req_valid_out <= 1'b0;
      frame_error_out <= 1'b0;
      if (rx_valid_in && rx_state == R_CSUM) begin
        if (!frame_ok) begin
          frame_error_out <= 1'b1;
        end else if (rx_buf[api_framer_pkg::REQ_OFS_TYPE - api_framer_pkg::HDR_BYTES] ==
                     api_framer_pkg::TYPE_REMOTE_REQ) begin
          if (rx_len < api_framer_pkg::REQ_MIN_LEN) begin
            frame_error_out <= 1'b1;
          end else begin
            req_valid_out <= 1'b1;
            req_out.frame_id <= rx_buf[api_framer_pkg::REQ_OFS_ID - api_framer_pkg::HDR_BYTES];
            req_out.dest_addr <= dec_addr;
            req_out.broadcast <= (dec_addr == api_framer_pkg::BROADCAST_ADDR);
            req_out.apply_changes <=
              (rx_buf[api_framer_pkg::REQ_OFS_OPTIONS - api_framer_pkg::HDR_BYTES] &
               api_framer_pkg::OPT_APPLY_CHANGES) != 8'h00;
            req_out.options_bad <=
              (rx_buf[api_framer_pkg::REQ_OFS_OPTIONS - api_framer_pkg::HDR_BYTES] &
               ~api_framer_pkg::OPT_APPLY_CHANGES) != 8'h00;
            req_out.reserved_bad <=
              {rx_buf[api_framer_pkg::REQ_OFS_RSVD_HI - api_framer_pkg::HDR_BYTES],
               rx_buf[api_framer_pkg::REQ_OFS_RSVD_LO - api_framer_pkg::HDR_BYTES]} !=
              api_framer_pkg::RSVD_ADDR16;
            req_out.cmd_name <=
              {rx_buf[api_framer_pkg::REQ_OFS_CMD_HI - api_framer_pkg::HDR_BYTES],
               rx_buf[api_framer_pkg::REQ_OFS_CMD_LO - api_framer_pkg::HDR_BYTES]};
            req_out.is_query <= (dec_param_len == 16'h0000);
            req_out.param_len <= dec_param_len[3:0];
            req_out.param <= dec_param;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------
  // transmit side
  // --------------------------------------------------------------

  // one response held until its frame has left; a zero frame id is taken and discarded
  assign resp_ready_out = !resp_pending &&
                          !(tx_src == SRC_RESP && (ser_start || ser_busy));

  // start a frame when the serializer is free and something waits
  assign launch = !ser_busy && !ser_start &&
                  (hw_pend || wdog_pend || wake_pend || sleep_pend || resp_pending);
  assign launch_modem = launch && (hw_pend || wdog_pend || wake_pend || sleep_pend);

  // modem code chosen by fixed priority, hardware reset first
  always_comb begin
    next_modem_code = api_framer_pkg::MDM_NET_SLEEP;
    if (hw_pend) begin
      next_modem_code = api_framer_pkg::MDM_HW_RESET;
    end else if (wdog_pend) begin
      next_modem_code = api_framer_pkg::MDM_WDOG_RESET;
    end else if (wake_pend) begin
      next_modem_code = api_framer_pkg::MDM_NET_WAKE;
    end
  end

  // pending modem events, a new event wins over its clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hw_pend <= 1'b1;
      wdog_pend <= 1'b0;
      wake_pend <= 1'b0;
      sleep_pend <= 1'b0;
    end else begin
      hw_pend <= hw_pend && !launch_modem;
      wdog_pend <= (wdog_pend && !(launch_modem && !hw_pend)) || wdog_reset_in;
      wake_pend <= (wake_pend && !(launch_modem && !hw_pend && !wdog_pend)) || net_wake_in;
      sleep_pend <= (sleep_pend && !(launch_modem && !hw_pend && !wdog_pend && !wake_pend)) ||
                    net_sleep_in;
    end
  end

  // held response, any number per request may pass through
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_pending <= 1'b0;
      resp_held <= '0;
    end else if (resp_valid_in && resp_ready_out) begin
      resp_held <= resp_in;
      resp_pending <= (resp_in.frame_id != 8'h00);
    end else if (launch && !launch_modem) begin
      resp_pending <= 1'b0;
    end
  end

  // frame source latched at launch
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ser_start <= 1'b0;
      tx_src <= SRC_MODEM;
      modem_code <= api_framer_pkg::MDM_HW_RESET;
    end else begin
      ser_start <= launch;
      if (launch) begin
        tx_src <= launch_modem ? SRC_MODEM : SRC_RESP;
        modem_code <= next_modem_code;
      end
    end
  end

  // body length per source, write replies carry no data
  always_comb begin
    if (tx_src == SRC_MODEM) begin
      body_len = api_framer_pkg::MDM_LEN;
    end else if (resp_held.is_query) begin
      body_len = api_framer_pkg::RSP_FIXED_LEN + {12'h000, resp_held.data_len};
    end else begin
      body_len = api_framer_pkg::RSP_FIXED_LEN;
    end
  end

  // body byte selected by position for the serializer
  always_comb begin
    rd_byte = 8'h00;
    if (tx_src == SRC_MODEM) begin
      if (rd_idx == 16'(api_framer_pkg::MDM_OFS_TYPE - api_framer_pkg::HDR_BYTES)) begin
        rd_byte = api_framer_pkg::TYPE_MODEM_STATUS;
      end else begin
        rd_byte = modem_code;
      end
    end else begin
      case (rd_idx)
        16'(api_framer_pkg::RSP_OFS_TYPE - api_framer_pkg::HDR_BYTES): begin
          rd_byte = api_framer_pkg::TYPE_CMD_RESP;
        end
        16'(api_framer_pkg::RSP_OFS_ID - api_framer_pkg::HDR_BYTES): begin
          rd_byte = resp_held.frame_id;
        end
        16'(api_framer_pkg::RSP_OFS_CMD_HI - api_framer_pkg::HDR_BYTES): begin
          rd_byte = resp_held.cmd_name[15:8];
        end
        16'(api_framer_pkg::RSP_OFS_CMD_LO - api_framer_pkg::HDR_BYTES): begin
          rd_byte = resp_held.cmd_name[7:0];
        end
        16'(api_framer_pkg::RSP_OFS_STATUS - api_framer_pkg::HDR_BYTES): begin
          rd_byte = resp_held.status;
        end
        default: begin
          rd_byte = resp_held.data[3'(rd_idx -
            16'(api_framer_pkg::RSP_OFS_DATA - api_framer_pkg::HDR_BYTES))];
        end
      endcase
    end
  end

  frame_serializer u_ser (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(ser_start),
    .body_len_in(body_len),
    .busy_out(ser_busy),
    .rd_idx_out(rd_idx),
    .rd_byte_in(rd_byte),
    .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out),
    .tx_ready_in(tx_ready_in)
  );

endmodule // api_remote_cmd_response_framer

// ==== framer_props.sv ====
/*
  checker on the framer top ports: tx framing, pulses, tx hold.
  assumes one clock and an async active low reset.
*/
module framer_props (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic rx_valid_in,
  input wire logic req_valid_out,
  input wire logic frame_error_out,
  input wire logic resp_valid_in,
  input wire logic resp_ready_out,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] idx;
  logic [15:0] len;
  logic [7:0] sum;
  wire logic take = tx_valid_out && tx_ready_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // position, length and body sum of the frame on tx
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx <= 16'h0000;
      len <= 16'h0000;
      sum <= 8'h00;
    end else if (take) begin
      idx <= (idx > 16'h0002 && idx == len + 16'h0003) ? 16'h0000 : idx + 16'h0001;
      if (idx == 16'h0001) len[15:8] <= tx_data_out;
      if (idx == 16'h0002) len[7:0] <= tx_data_out;
      sum <= (idx < 16'h0003) ? 8'h00 : sum + tx_data_out;
    end
  end
  a_frame_delim: assert property (take && idx == 16'h0000 |-> tx_data_out == 8'h7E)
    else $error("frame does not open with delimiter");
  a_frame_csum: assert property (take && idx > 16'h0002 && idx == len + 16'h0003
    |-> tx_data_out == 8'hFF - sum) else $error("bad tx checksum");
  a_frame_type: assert property (take && idx == 16'h0003
    |-> tx_data_out inside {8'h88, 8'h8A}) else $error("bad tx frame type");
  a_modem_len: assert property (take && idx == 16'h0003 && tx_data_out == 8'h8A
    |-> len == 16'h0002) else $error("modem frame length wrong");
  a_resp_len: assert property (take && idx == 16'h0003 && tx_data_out == 8'h88
    |-> len >= 16'h0005 && len <= 16'h000D) else $error("response length wrong");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in
    |=> tx_valid_out && $stable(tx_data_out)) else $error("tx byte dropped");
  a_req_pulse: assert property (req_valid_out |=> !req_valid_out)
    else $error("request pulse too long");
  a_err_pulse: assert property (frame_error_out |=> !frame_error_out)
    else $error("error pulse too long");
  a_rx_cause: assert property (req_valid_out || frame_error_out |-> $past(rx_valid_in)
    && !(req_valid_out && frame_error_out)) else $error("rx verdict without byte");
  c_req: cover property (req_valid_out);
  c_err: cover property (frame_error_out);
  c_resp: cover property (resp_valid_in && resp_ready_out);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule // framer_props

bind api_remote_cmd_response_framer framer_props props_u (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .rx_valid_in(rx_valid_in),
  .req_valid_out(req_valid_out), .frame_error_out(frame_error_out),
  .resp_valid_in(resp_valid_in), .resp_ready_out(resp_ready_out),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in));

// ==== host_model.sv ====
/*
  host side of the uart byte stream: sends request frames, collects tx bytes.
  assumes the framer takes rx bytes on the rising edge.
*/
module host_model (
  input wire logic core_clk_in,
  input wire logic slow_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [1:0] tick = 2'h0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'hA5;
  end
  // collect every byte taken from the framer
  always @(posedge core_clk_in) if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
  // ready one cycle in four when slow
  always @(negedge core_clk_in) begin
    tick <= tick + 2'h1;
    tx_ready_out <= !slow_in || tick == 2'h3;
  end
  // delimiter, length high first, body, checksum; idle data is the inverse
  task automatic send_frame(input logic [7:0] body[$], input logic bad_sum);
    logic [7:0] sum;
    logic [7:0] all[$];
    sum = 8'h00;
    foreach (body[i]) sum += body[i];
    all = {8'h7E, 8'h00, 8'(body.size()), body, (8'hFF - sum) ^ {7'h00, bad_sum}};
    foreach (all[i]) begin
      @(negedge core_clk_in);
      rx_valid_out = 1'b1;
      rx_data_out = all[i];
    end
    @(negedge core_clk_in);
    rx_valid_out = 1'b0;
    rx_data_out = ~rx_data_out;
  endtask
  // remote request: type, id, address high first, reserved, options, name, params
  task automatic send_req(input logic [7:0] id, input logic [63:0] addr, input logic [7:0] opt,
      input logic [15:0] rsvd, input logic [15:0] name, input logic [7:0] prm[$],
      input logic bad_sum);
    logic [7:0] b[$];
    b = {8'h17, id};
    for (int i = 7; i >= 0; i--) b.push_back(addr[i*8 +: 8]);
    b = {b, rsvd[15:8], rsvd[7:0], opt, name[15:8], name[7:0], prm};
    send_frame(b, bad_sum);
  endtask
endmodule // host_model

// ==== api_remote_cmd_response_framer_tb_top.sv ====
/*
  testbench for the api framer: requests in, responses and modem frames out.
  assumes the host model and the bound checker are compiled alongside.
*/
module api_remote_cmd_response_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, rst_n_in, rx_valid_in, req_valid_out, frame_error_out, slow;
  logic resp_valid_in, resp_ready_out, wdog_reset_in, net_wake_in, net_sleep_in;
  logic tx_valid_out, tx_ready_in;
  logic [7:0] rx_data_in, tx_data_out;
  logic [7:0] none[$];
  api_framer_pkg::remote_req_s req_out;
  api_framer_pkg::cmd_resp_s resp_in;
  int err_count, checks, req_seen, fe_seen;

  api_remote_cmd_response_framer dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .req_valid_out(req_valid_out),
    .req_out(req_out), .frame_error_out(frame_error_out), .resp_valid_in(resp_valid_in),
    .resp_ready_out(resp_ready_out), .resp_in(resp_in), .wdog_reset_in(wdog_reset_in),
    .net_wake_in(net_wake_in), .net_sleep_in(net_sleep_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in));
  host_model host_u (.core_clk_in(core_clk_in), .slow_in(slow), .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in), .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
    .tx_ready_out(tx_ready_in));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // count the one-cycle verdict pulses
  always @(posedge core_clk_in) begin
    if (req_valid_out === 1'b1) req_seen++;
    if (frame_error_out === 1'b1) fe_seen++;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // wait for one whole frame on tx and compare it byte by byte
  task automatic expect_frame(input logic [7:0] body[$]);
    logic [7:0] sum;
    logic [7:0] exp[$];
    int n;
    sum = 8'h00;
    foreach (body[i]) sum += body[i];
    exp = {8'h7E, 8'h00, 8'(body.size()), body, 8'hFF - sum};
    n = 0;
    while (host_u.got_q.size() < exp.size() && n < 3000) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n == 3000) begin
      err_count++;
      close_out();
    end
    foreach (exp[i]) check("tx byte", host_u.got_q.pop_front(), exp[i]);
  endtask
  // hand one response over the valid/ready handshake
  task automatic respond(input logic [7:0] id, input logic [7:0] st, input logic q);
    int n;
    n = 0;
    @(negedge core_clk_in);
    resp_in = '{frame_id:id, cmd_name:16'h4248, status:st, is_query:q, data_len:4'h2,
      data:64'h0807060504030201};
    resp_valid_in = 1'b1;
    while (resp_ready_out !== 1'b1 && n < 3000) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n == 3000) begin
      err_count++;
      close_out();
    end
    @(negedge core_clk_in);
    resp_valid_in = 1'b0;
  endtask
  // body of the response frame that the framer must send
  function automatic void resp_body(input logic [7:0] id, input logic [7:0] st, input logic q,
      output logic [7:0] b[$]);
    b = {8'h88, id, 8'h42, 8'h48, st};
    if (q) b = {b, 8'h01, 8'h02};
  endfunction

  initial begin
    logic [7:0] b[$];
    {rst_n_in, resp_valid_in, wdog_reset_in, net_wake_in, net_sleep_in, slow} = 6'h00;
    resp_in = '0;
    {err_count, checks, req_seen, fe_seen} = '0;
    repeat (10) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    expect_frame('{8'h8A, 8'h00});
    // broadcast query with apply-changes
    host_u.send_req(8'h01, 64'h0000_0000_0000_FFFF, 8'h02, 16'hFFFE, 16'h4248, none, 1'b0);
    repeat (3) @(negedge core_clk_in);
    check("req count", req_seen, 1);
    check("query req", {req_out.frame_id, req_out.broadcast, req_out.apply_changes,
      req_out.options_bad, req_out.reserved_bad, req_out.is_query, req_out.cmd_name},
      {8'h01, 5'b11001, 16'h4248});
    // unicast write with stray option bit and wrong reserved bytes
    host_u.send_req(8'h02, 64'h0011_2233_4455_6677, 8'h03, 16'hFFFF, 16'h4248, '{8'h01}, 1'b0);
    repeat (3) @(negedge core_clk_in);
    check("write req", {req_out.frame_id, req_out.broadcast, req_out.options_bad,
      req_out.reserved_bad, req_out.is_query, req_out.param_len, req_out.param[0]},
      {8'h02, 4'b0110, 4'h1, 8'h01});
    check("write addr", req_out.dest_addr, 64'h0011_2233_4455_6677);
    // corrupted checksum, then a good frame right behind it
    host_u.send_req(8'h03, 64'h0000_0000_0000_FFFF, 8'h00, 16'hFFFE, 16'h4248, none, 1'b1);
    host_u.send_req(8'h04, 64'h0000_0000_0000_FFFF, 8'h00, 16'hFFFE, 16'h4248, none, 1'b0);
    repeat (3) @(negedge core_clk_in);
    check("verdicts", {fe_seen[7:0], req_seen[7:0], req_out.frame_id}, 24'h01_03_04);
    // short request and a foreign type, both with good checksums
    host_u.send_frame('{8'h17, 8'h09}, 1'b0);
    host_u.send_frame('{8'h08, 8'h01}, 1'b0);
    repeat (3) @(negedge core_clk_in);
    check("short and foreign", {fe_seen[7:0], req_seen[7:0]}, 16'h02_03);
    // every status code, with the host stalling tx
    slow = 1'b1;
    for (int s = 0; s < 4; s++) begin
      respond(8'h01, 8'(s), 1'b1);
      resp_body(8'h01, 8'(s), 1'b1, b);
      expect_frame(b);
    end
    slow = 1'b0;
    // a silent id 0, then two replies to one request and a write reply
    respond(8'h00, 8'h00, 1'b1);
    respond(8'h05, 8'h00, 1'b1);
    respond(8'h05, 8'h00, 1'b1);
    respond(8'h02, 8'h00, 1'b0);
    resp_body(8'h05, 8'h00, 1'b1, b);
    expect_frame(b);
    expect_frame(b);
    resp_body(8'h02, 8'h00, 1'b0, b);
    expect_frame(b);
    // three modem events at once leave in priority order
    @(negedge core_clk_in);
    {wdog_reset_in, net_wake_in, net_sleep_in} = 3'b111;
    @(negedge core_clk_in);
    {wdog_reset_in, net_wake_in, net_sleep_in} = 3'b000;
    expect_frame('{8'h8A, 8'h01});
    expect_frame('{8'h8A, 8'h0B});
    expect_frame('{8'h8A, 8'h0C});
    repeat (20) @(negedge core_clk_in);
    check("tx leftover", host_u.got_q.size(), 0);
    close_out();
  end
endmodule // api_remote_cmd_response_framer_tb_top
